// >>> rtl/rbr_consts.vh
// Constants for the receive bit-check and bi-phase receiver block.
`ifndef RBR_CONSTS_VH
`define RBR_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define RBR_OFF_DATA 8'h00
`define RBR_OFF_CTRL1 8'h04
`define RBR_OFF_CTRL3 8'h0c
`define RBR_OFF_CTRL4 8'h10
`define RBR_OFF_CTRL5 8'h14
`define RBR_OFF_CTRL6 8'h18
`define RBR_OFF_CTRL7 8'h1c
`define RBR_OFF_STATUS 8'h20
`define RBR_OFF_IRQCLR 8'h24

// ****************************************
// Field positions
// ****************************************
`define RBR_C1_OPM_LSB 0
`define RBR_C1_IRL_LSB 3
`define RBR_C1_TMODE 5
`define RBR_C1_PMODE 6
`define RBR_C3_CLKON 0
`define RBR_C4_ASK 7
`define RBR_C5_LIM_LSB 0
`define RBR_C5_NBC_LSB 6
`define RBR_ST_CNT_LSB 0
`define RBR_ST_STATE_LSB 5
`define RBR_ST_IRQ 8

// ****************************************
// Reset values
// ****************************************
`define RBR_RST_CTRL1 8'h00
`define RBR_RST_CTRL4 8'h00
`define RBR_RST_CTRL5 8'h4e
`define RBR_RST_CTRL6 8'h18
`define RBR_RST_CTRL7 8'h00

// ****************************************
// Mode codes and interrupt levels
// ****************************************
`define RBR_OPM_RX_POLL 3'b010
`define RBR_OPM_RX_CONT 3'b011
`define RBR_IRQ_LVL0 5'h01
`define RBR_IRQ_LVL1 5'h02
`define RBR_IRQ_LVL2 5'h04
`define RBR_IRQ_LVL3 5'h08

// ****************************************
// Timing
// ****************************************
`define RBR_CLK_MHZ 200
`define RBR_SIGPROC_NS 1000
`define RBR_SIGPROC_CYC ((`RBR_SIGPROC_NS * `RBR_CLK_MHZ + 999) / 1000)

`endif

// >>> rtl/rbr_receiver.v
// Receive bit-check, Manchester decoder and byte buffer with an AXI4-Lite register slave.
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "rbr_consts.vh"

// Functional notes
// - Leaving sleep: enable PLL, await lock, then signal processing, then check data.
// - Bit count setting 0,1,2,3 gives 0,6,12,18 interval checks.
// - Interval inside window continues checking; outside aborts check to sleep when polling, to signal processing when continuous.
// - Window counter advances per tick; edges compare it to both limits.
// - Interval passes when counter at edge lies within programmed limits.
// - Edge arriving while counter below lower limit fails the check.
// - Counter reaching upper limit fails the check without waiting for edge.
// - Lower time is lower setting ticks; upper time is upper setting minus one.
// - Lower limit six bits in control 5; upper limit six bits in control 6.
// - All checks passed: enter receiving and set host clock-on bit.
// - On entering receiving, raise interrupt only if transparent and pattern bits zero.
// - Transparent mode with chip select inactive drives stream onto serial out pin.
// - Non-transparent mode buffers Manchester data, readable by controller any time.
// - Receiving accepts only T and 2T intervals; T uses the check limits.
// - 2T limits: sum minus/plus half difference, rounded up, upper less a tick.
// - After start bit, bytes are stored; start bit is first bit of byte one.
// - Buffer holds 16 bytes; further bytes overwrite the oldest stored ones.
// - Byte counter rises per stored byte, falls per byte read, readable.
// - Interrupt when counter, counting up, reaches selected interrupt level.
// - Bit error raises interrupt, discards byte, returns to start-up.
// - Writing control 1,4,5,6,7 while receiving resets buffer logic and counter.
// - Rising transition stores 1, falling stores 0; transparent pin follows level.
// - Mode bits 010 select polling receive, 011 continuous receive.
module rbr_receiver #(
	parameter ADDR_W = 8,
	parameter BUF_DEPTH = 16,
	parameter CNT_W = 8
) (
	// Clock and reset.
	input wire ref_clk_i,
	input wire nrst_i,
	// AXI4-Lite write channels.
	input wire [ADDR_W-1:0] s_axi_awaddr_i,
	input wire s_axi_awvalid_i,
	output wire s_axi_awready_o,
	input wire [31:0] s_axi_wdata_i,
	input wire [3:0] s_axi_wstrb_i,
	input wire s_axi_wvalid_i,
	output wire s_axi_wready_o,
	output wire [1:0] s_axi_bresp_o,
	output wire s_axi_bvalid_o,
	input wire s_axi_bready_i,
	// AXI4-Lite read channels.
	input wire [ADDR_W-1:0] s_axi_araddr_i,
	input wire s_axi_arvalid_i,
	output wire s_axi_arready_o,
	output wire [31:0] s_axi_rdata_o,
	output wire [1:0] s_axi_rresp_o,
	output wire s_axi_rvalid_o,
	input wire s_axi_rready_i,
	// Radio side.
	input wire demod_i,
	input wire tick_i,
	input wire pll_lock_i,
	input wire wake_i,
	input wire cs_active_i,
	output wire pll_en_o,
	output wire sigproc_en_o,
	output wire rx_active_o,
	// Host pins.
	output wire irq_o,
	output wire serial_out_o,
	output wire serial_out_oe_o
);

	localparam [2:0] ST_OFF = 3'd0;
	localparam [2:0] ST_SLEEP = 3'd1;
	localparam [2:0] ST_PLL = 3'd2;
	localparam [2:0] ST_SIGP = 3'd3;
	localparam [2:0] ST_CHECK = 3'd4;
	localparam [2:0] ST_RECV = 3'd5;
	localparam [15:0] SIGP_CYC = `RBR_SIGPROC_CYC;
	localparam [4:0] FULL_CNT = BUF_DEPTH;

	// ****************************************
	// Reset synchroniser
	// ****************************************
	reg rst_q1_reg;
	reg rst_q2_reg;
	wire rst_n;

	// The release of reset is taken through two flip-flops.
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_q1_reg <= 1'b0;
			rst_q2_reg <= 1'b0;
		end else begin
			rst_q1_reg <= 1'b1;
			rst_q2_reg <= rst_q1_reg;
		end
	end
	assign rst_n = rst_q2_reg;

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	reg aw_full_reg;
	reg w_full_reg;
	reg [ADDR_W-1:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;
	reg bvalid_reg;
	reg [1:0] bresp_reg;
	reg rvalid_reg;
	reg [1:0] rresp_reg;
	reg [31:0] rdata_reg;
	reg [7:0] ctrl1_reg;
	reg [7:0] ctrl4_reg;
	reg [7:0] ctrl5_reg;
	reg [7:0] ctrl6_reg;
	reg [7:0] ctrl7_reg;
	reg [2:0] state_reg;
	reg [4:0] byte_cnt_reg;
	reg clk_on_reg;
	reg irq_reg;
	reg [7:0] mem [0:BUF_DEPTH-1];
	reg [3:0] rd_ptr_reg;
	reg [3:0] wr_ptr_reg;
	wire wr_do;
	wire ar_fire;
	wire [7:0] wa;
	wire [7:0] ra;
	wire wr_ok;
	wire rd_ok;
	wire lane0;
	wire cfg_wr;
	wire rd_pop;
	wire irq_clr;
	wire clk_on_wr;
	reg [31:0] rmux;

	assign s_axi_awready_o = !aw_full_reg;
	assign s_axi_wready_o = !w_full_reg;
	assign s_axi_bvalid_o = bvalid_reg;
	assign s_axi_bresp_o = bresp_reg;
	assign s_axi_arready_o = !rvalid_reg;
	assign s_axi_rvalid_o = rvalid_reg;
	assign s_axi_rresp_o = rresp_reg;
	assign s_axi_rdata_o = rdata_reg;
	assign wr_do = aw_full_reg & w_full_reg & !bvalid_reg;
	assign ar_fire = s_axi_arvalid_i & !rvalid_reg;
	assign wa = aw_addr_reg[7:0];
	assign ra = s_axi_araddr_i[7:0];
	assign wr_ok = (wa == `RBR_OFF_CTRL1) | (wa == `RBR_OFF_CTRL3) | (wa == `RBR_OFF_CTRL4) |
		(wa == `RBR_OFF_CTRL5) | (wa == `RBR_OFF_CTRL6) | (wa == `RBR_OFF_CTRL7) | (wa == `RBR_OFF_IRQCLR);
	assign rd_ok = (ra == `RBR_OFF_DATA) | (ra == `RBR_OFF_CTRL1) | (ra == `RBR_OFF_CTRL3) |
		(ra == `RBR_OFF_CTRL4) | (ra == `RBR_OFF_CTRL5) | (ra == `RBR_OFF_CTRL6) |
		(ra == `RBR_OFF_CTRL7) | (ra == `RBR_OFF_STATUS);
	assign lane0 = wr_do & w_strb_reg[0];
	assign cfg_wr = lane0 & ((wa == `RBR_OFF_CTRL1) | (wa == `RBR_OFF_CTRL4) | (wa == `RBR_OFF_CTRL5) |
		(wa == `RBR_OFF_CTRL6) | (wa == `RBR_OFF_CTRL7));
	assign irq_clr = lane0 & (wa == `RBR_OFF_IRQCLR);
	assign clk_on_wr = lane0 & (wa == `RBR_OFF_CTRL3);
	assign rd_pop = ar_fire & (ra == `RBR_OFF_DATA) & (byte_cnt_reg != 5'h00);

	// Read data selection; unmapped words read as zero.
	always @* begin
		rmux = 32'h0000_0000;
		case (ra)
			`RBR_OFF_DATA: rmux[7:0] = (byte_cnt_reg != 5'h00) ? mem[rd_ptr_reg] : 8'h00;
			`RBR_OFF_CTRL1: rmux[7:0] = ctrl1_reg;
			`RBR_OFF_CTRL3: rmux[`RBR_C3_CLKON] = clk_on_reg;
			`RBR_OFF_CTRL4: rmux[7:0] = ctrl4_reg;
			`RBR_OFF_CTRL5: rmux[7:0] = ctrl5_reg;
			`RBR_OFF_CTRL6: rmux[7:0] = ctrl6_reg;
			`RBR_OFF_CTRL7: rmux[7:0] = ctrl7_reg;
			`RBR_OFF_STATUS: rmux[8:0] = {irq_reg, state_reg, byte_cnt_reg};
			default: rmux = 32'h0000_0000;
		endcase
	end

	// Address and data are held until both are present; the answer follows one cycle later.
	always @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_addr_reg <= {ADDR_W{1'b0}};
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'b00;
			rvalid_reg <= 1'b0;
			rresp_reg <= 2'b00;
			rdata_reg <= 32'h0000_0000;
		end else begin
			if (s_axi_awvalid_i && !aw_full_reg) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && !w_full_reg) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata_i;
				w_strb_reg <= s_axi_wstrb_i;
			end
			if (wr_do) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_ok ? 2'b00 : 2'b10;
			end else if (s_axi_bready_i) begin
				bvalid_reg <= 1'b0;
			end
			if (ar_fire) begin
				rvalid_reg <= 1'b1;
				rresp_reg <= rd_ok ? 2'b00 : 2'b10;
				rdata_reg <= rmux;
			end else if (s_axi_rready_i) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	// Software settings; all fields sit in the low byte.
	always @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1_reg <= `RBR_RST_CTRL1;
			ctrl4_reg <= `RBR_RST_CTRL4;
			ctrl5_reg <= `RBR_RST_CTRL5;
			ctrl6_reg <= `RBR_RST_CTRL6;
			ctrl7_reg <= `RBR_RST_CTRL7;
		end else if (lane0) begin
			if (wa == `RBR_OFF_CTRL1) ctrl1_reg <= w_data_reg[7:0];
			if (wa == `RBR_OFF_CTRL4) ctrl4_reg <= w_data_reg[7:0];
			if (wa == `RBR_OFF_CTRL5) ctrl5_reg <= w_data_reg[7:0];
			if (wa == `RBR_OFF_CTRL6) ctrl6_reg <= w_data_reg[7:0];
			if (wa == `RBR_OFF_CTRL7) ctrl7_reg <= w_data_reg[7:0];
		end
	end

	// ****************************************
	// Windows and decode terms
	// ****************************************
	reg [CNT_W-1:0] win_cnt_reg;
	reg [4:0] checks_reg;
	reg [15:0] sp_cnt_reg;
	reg demod_q_reg;
	reg synced_reg;
	reg at_centre_reg;
	reg [2:0] bitn_reg;
	reg [6:0] shreg_reg;
	reg so_reg;
	reg so_oe_reg;
	wire [2:0] opm;
	wire [2:0] opm_new;
	wire is_rx;
	wire new_rx;
	wire polling;
	wire tmode;
	wire pmode;
	wire [1:0] nbc;
	wire [4:0] nchecks;
	wire [7:0] lo;
	wire [7:0] hi;
	wire [7:0] diff;
	wire [7:0] lo2;
	wire [7:0] hi2;
	wire edge_seen;
	wire iv_t;
	wire iv_2t;
	wire bad_edge;
	wire timeout;
	wire bit_now;
	wire store;
	wire [4:0] irq_lvl;

	assign opm = ctrl1_reg[`RBR_C1_OPM_LSB +: 3];
	assign opm_new = (wa == `RBR_OFF_CTRL1) ? w_data_reg[`RBR_C1_OPM_LSB +: 3] : opm;
	assign is_rx = (opm == `RBR_OPM_RX_POLL) | (opm == `RBR_OPM_RX_CONT);
	assign new_rx = (opm_new == `RBR_OPM_RX_POLL) | (opm_new == `RBR_OPM_RX_CONT);
	assign polling = (opm == `RBR_OPM_RX_POLL);
	assign tmode = ctrl1_reg[`RBR_C1_TMODE];
	assign pmode = ctrl1_reg[`RBR_C1_PMODE];
	assign nbc = ctrl5_reg[`RBR_C5_NBC_LSB +: 2];
	assign nchecks = {1'b0, nbc, 2'b00} + {2'b00, nbc, 1'b0};
	assign lo = {2'b00, ctrl5_reg[`RBR_C5_LIM_LSB +: 6]};
	assign hi = {2'b00, ctrl6_reg[`RBR_C5_LIM_LSB +: 6]};
	assign diff = (hi > lo) ? (hi - lo) : 8'h00;
	assign lo2 = lo + hi - {1'b0, diff[7:1]};
	assign hi2 = lo + hi + {1'b0, diff[7:1]} + {7'h00, diff[0]};
	assign edge_seen = demod_i ^ demod_q_reg;
	assign iv_t = (win_cnt_reg >= lo) && (win_cnt_reg < hi);
	assign iv_2t = (win_cnt_reg >= lo2) && (win_cnt_reg < hi2);
	assign bad_edge = edge_seen & (!(iv_t | iv_2t) | (iv_2t & synced_reg & !at_centre_reg));
	assign timeout = !edge_seen & (win_cnt_reg >= hi2);
	// centre edge direction is the bit
	assign bit_now = edge_seen & !bad_edge & (iv_2t | (iv_t & synced_reg & !at_centre_reg));
	assign store = (state_reg == ST_RECV) & !tmode & bit_now & (bitn_reg == 3'd7);
	assign irq_lvl = (ctrl1_reg[`RBR_C1_IRL_LSB +: 2] == 2'd0) ? `RBR_IRQ_LVL0 :
		(ctrl1_reg[`RBR_C1_IRL_LSB +: 2] == 2'd1) ? `RBR_IRQ_LVL1 :
		(ctrl1_reg[`RBR_C1_IRL_LSB +: 2] == 2'd2) ? `RBR_IRQ_LVL2 : `RBR_IRQ_LVL3;

	always @(posedge ref_clk_i) begin
		if (store) mem[wr_ptr_reg] <= {shreg_reg, demod_i};
	end

	// ****************************************
	// Sequencer, bit-check and buffer control
	// ****************************************
	always @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_OFF;
			win_cnt_reg <= {CNT_W{1'b0}};
			checks_reg <= 5'h00;
			sp_cnt_reg <= 16'h0000;
			demod_q_reg <= 1'b0;
			synced_reg <= 1'b0;
			at_centre_reg <= 1'b0;
			bitn_reg <= 3'd0;
			shreg_reg <= 7'h00;
			byte_cnt_reg <= 5'h00;
			rd_ptr_reg <= 4'h0;
			wr_ptr_reg <= 4'h0;
			clk_on_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			demod_q_reg <= demod_i;
			if (clk_on_wr) clk_on_reg <= w_data_reg[`RBR_C3_CLKON];
			if (irq_clr) irq_reg <= 1'b0;
			if (tick_i && (win_cnt_reg != {CNT_W{1'b1}})) win_cnt_reg <= win_cnt_reg + 1'b1;
			// counter up on store, down on read
			if (rd_pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
				if (!store) byte_cnt_reg <= byte_cnt_reg - 1'b1;
			end
			if (store) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
				if (byte_cnt_reg == FULL_CNT) begin
					if (!rd_pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
				end else if (!rd_pop) begin
					byte_cnt_reg <= byte_cnt_reg + 1'b1;
					if ((byte_cnt_reg + 5'h01) == irq_lvl) irq_reg <= 1'b1;
				end
			end
			if (cfg_wr && (state_reg == ST_RECV)) begin
				byte_cnt_reg <= 5'h00;
				rd_ptr_reg <= 4'h0;
				wr_ptr_reg <= 4'h0;
				sp_cnt_reg <= 16'h0000;
				state_reg <= new_rx ? ST_SIGP : ST_OFF;
			end else if (!is_rx) begin
				state_reg <= ST_OFF;
			end else begin
				case (state_reg)
					ST_OFF: begin
						state_reg <= polling ? ST_SLEEP : ST_PLL;
					end
					ST_SLEEP: begin
						if (wake_i || !polling) state_reg <= ST_PLL;
					end
					ST_PLL: begin
						sp_cnt_reg <= 16'h0000;
						if (pll_lock_i) state_reg <= ST_SIGP;
					end
					ST_SIGP: begin
						sp_cnt_reg <= sp_cnt_reg + 1'b1;
						win_cnt_reg <= {CNT_W{1'b0}};
						checks_reg <= 5'h00;
						synced_reg <= 1'b0;
						at_centre_reg <= 1'b0;
						bitn_reg <= 3'd0;
						if (sp_cnt_reg >= SIGP_CYC - 16'h0001) begin
							if (nchecks == 5'h00) begin
								state_reg <= ST_RECV;
								clk_on_reg <= 1'b1;
								if (!tmode && !pmode) irq_reg <= 1'b1;
							end else begin
								state_reg <= ST_CHECK;
							end
						end
					end
					ST_CHECK: begin
						if (edge_seen) begin
							win_cnt_reg <= {CNT_W{1'b0}};
							// edge below lower limit; an edge at the upper limit also fails.
							if ((win_cnt_reg < lo) || (win_cnt_reg >= hi)) begin
								state_reg <= polling ? ST_SLEEP : ST_SIGP;
								sp_cnt_reg <= 16'h0000;
							end else if (checks_reg + 5'h01 == nchecks) begin
								state_reg <= ST_RECV;
								clk_on_reg <= 1'b1;
								if (!tmode && !pmode) irq_reg <= 1'b1;
							end else begin
								checks_reg <= checks_reg + 1'b1;
							end
						end else if (win_cnt_reg >= hi) begin
							state_reg <= polling ? ST_SLEEP : ST_SIGP;
							sp_cnt_reg <= 16'h0000;
						end
					end
					ST_RECV: begin
						if (edge_seen) win_cnt_reg <= {CNT_W{1'b0}};
						if (!tmode) begin
							if (bad_edge || timeout) begin
								irq_reg <= 1'b1;
								state_reg <= ST_PLL;
							end else if (bit_now) begin
								synced_reg <= 1'b1;
								at_centre_reg <= 1'b1;
								bitn_reg <= synced_reg ? bitn_reg + 1'b1 : 3'd1;
								shreg_reg <= synced_reg ? {shreg_reg[5:0], demod_i} : {6'h00, demod_i};
							end else if (edge_seen && synced_reg) begin
								at_centre_reg <= 1'b0;
							end
						end
					end
					default: state_reg <= ST_OFF;
				endcase
			end
		end
	end

	always @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			so_reg <= 1'b0;
			so_oe_reg <= 1'b0;
		end else begin
			so_oe_reg <= (state_reg == ST_RECV) & tmode & !cs_active_i;
			so_reg <= demod_i;
		end
	end

	// Pin outputs.
	assign serial_out_o = so_reg;
	assign serial_out_oe_o = so_oe_reg;
	assign irq_o = irq_reg;
	assign pll_en_o = (state_reg == ST_PLL) | (state_reg == ST_SIGP) | (state_reg == ST_CHECK) | (state_reg == ST_RECV);
	assign sigproc_en_o = (state_reg == ST_SIGP) | (state_reg == ST_CHECK) | (state_reg == ST_RECV);
	assign rx_active_o = sigproc_en_o;

endmodule
`default_nettype wire

// >>> verif/rbr_receiver_properties.sv
// Port checker for the receive bit-check block.
`timescale 1ns/100ps
`default_nettype none
module rbr_receiver_properties (
	// Clock and reset.
	input wire ref_clk_i,
	input wire nrst_i,
	// Register bus handshakes.
	input wire s_axi_awvalid_i,
	input wire s_axi_awready_o,
	input wire s_axi_wvalid_i,
	input wire s_axi_wready_o,
	input wire s_axi_bvalid_o,
	input wire s_axi_bready_i,
	input wire s_axi_arvalid_i,
	input wire s_axi_arready_o,
	input wire s_axi_rvalid_o,
	input wire s_axi_rready_i,
	// Radio and host pins.
	input wire demod_i,
	input wire pll_lock_i,
	input wire cs_active_i,
	input wire pll_en_o,
	input wire sigproc_en_o,
	input wire serial_out_o,
	input wire serial_out_oe_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!nrst_i);
	// Both write halves taken at one edge.
	sequence seq_wr_take;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	// Address held one cycle, then the response shows.
	sequence seq_b_due;
		!s_axi_awready_o ##1 s_axi_bvalid_o;
	endsequence
	chk_wr_answer: assert property (seq_wr_take |=> seq_b_due)
		else $error("write response not on time");
	chk_b_once: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
		else $error("write response repeated");
	chk_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read data not on time");
	chk_ar_busy: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read address accepted while data pending");
	chk_r_once: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
		else $error("read data repeated");
	chk_pll_first: assert property (sigproc_en_o |-> pll_en_o)
		else $error("signal processing without pll");
	chk_lock_before: assert property ($rose(sigproc_en_o) |-> $past(pll_lock_i))
		else $error("signal processing started before lock");
	chk_oe_cs: assert property (serial_out_oe_o |-> !$past(cs_active_i))
		else $error("serial out driven while selected");
	chk_oe_rx: assert property (serial_out_oe_o |-> $past(sigproc_en_o))
		else $error("serial out driven outside receiving");
	chk_out_follow: assert property (serial_out_oe_o |-> serial_out_o == $past(demod_i))
		else $error("serial out does not follow stream");
endmodule
bind rbr_receiver rbr_receiver_properties i_rbr_receiver_properties (
	.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
	.s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
	.s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
	.s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
	.s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
	.s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .demod_i(demod_i), .pll_lock_i(pll_lock_i),
	.cs_active_i(cs_active_i), .pll_en_o(pll_en_o), .sigproc_en_o(sigproc_en_o),
	.serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o)
);
`default_nettype wire

// >>> verif/rbr_radio_model.sv
// Radio front end model: demodulator stream, window tick and pll lock.
`timescale 1ns/100ps
`default_nettype none
module rbr_radio_model (
	// Clock.
	input wire logic clk_i,
	// Receiver start-up state.
	input wire logic sigproc_en_i,
	// Radio outputs.
	output logic demod_o,
	output logic tick_o,
	output logic pll_lock_o
);
	// Idle levels before any telegram.
	initial begin
		demod_o = 1'b1;
		tick_o = 1'b0;
		pll_lock_o = 1'b0;
	end
	// Window tick pulses every second cycle.
	always @(posedge clk_i) begin
		tick_o <= ~tick_o;
	end
	// Locks, waits out start-up, then sends zeros, then two bytes, half bits of half ticks.
	task automatic run(input int half);
		logic [31:0] bits;
		bits = {16'h0000, 8'ha5, 8'h3c};
		// Preburst level is set before start-up, so the first interval checked is a whole one.
		demod_o <= ~bits[31];
		repeat (20) @(posedge clk_i);
		pll_lock_o <= 1'b1;
		@(posedge sigproc_en_i);
		repeat (200) @(posedge clk_i);
		for (int i = 31; i >= 0; i--) begin
			demod_o <= ~bits[i];
			repeat (2 * half) @(posedge clk_i);
			demod_o <= bits[i];
			repeat (2 * half) @(posedge clk_i);
		end
		pll_lock_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> verif/rbr_receiver_tb.sv
// Self-checking bench for the receive bit-check block.
`timescale 1ns/100ps
`default_nettype none
module rbr_receiver_tb;
	// Bench drive and observed pins.
	logic ref_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [7:0] aw_addr = 8'h00;
	logic [31:0] w_data = 32'h0;
	logic [3:0] w_strb = 4'hf;
	logic [7:0] ar_addr = 8'h00;
	logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
	logic wake = 1'b0, cs_active = 1'b0;
	wire aw_ready, w_ready, b_valid, ar_ready, r_valid;
	wire [1:0] b_resp, r_resp;
	wire [31:0] r_data;
	wire demod, tick, pll_lock, pll_en, sigproc_en, rx_active, irq, sout, sout_oe;
	int num_errors = 0;
	int checks = 0;
	int hs [2] = '{8, 30};
	logic [31:0] dv;
	logic [1:0] rv;
	always #2.5 ref_clk_i = ~ref_clk_i;
	// Device and radio front end.
	rbr_receiver i_rbr_receiver (
		.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.s_axi_awaddr_i(aw_addr), .s_axi_awvalid_i(aw_valid), .s_axi_awready_o(aw_ready),
		.s_axi_wdata_i(w_data), .s_axi_wstrb_i(w_strb), .s_axi_wvalid_i(w_valid), .s_axi_wready_o(w_ready),
		.s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_valid), .s_axi_bready_i(b_ready),
		.s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_valid), .s_axi_arready_o(ar_ready),
		.s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_valid), .s_axi_rready_i(r_ready),
		.demod_i(demod), .tick_i(tick), .pll_lock_i(pll_lock), .wake_i(wake), .cs_active_i(cs_active),
		.pll_en_o(pll_en), .sigproc_en_o(sigproc_en), .rx_active_o(rx_active),
		.irq_o(irq), .serial_out_o(sout), .serial_out_oe_o(sout_oe)
	);
	rbr_radio_model i_rbr_radio_model (
		.clk_i(ref_clk_i), .sigproc_en_i(sigproc_en), .demod_o(demod), .tick_o(tick), .pll_lock_o(pll_lock)
	);
	// Counts a comparison and reports a mismatch.
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Write: both halves offered together, each released once taken, then the response.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic at, wt, bt;
		@(posedge ref_clk_i);
		aw_addr <= a;
		w_data <= d;
		aw_valid <= 1'b1;
		w_valid <= 1'b1;
		b_ready <= 1'b1;
		bt = 1'b0;
		while (!bt) begin
			@(negedge ref_clk_i);
			at = aw_valid && aw_ready === 1'b1;
			wt = w_valid && w_ready === 1'b1;
			bt = b_valid === 1'b1;
			r = b_resp;
			@(posedge ref_clk_i);
			if (at) aw_valid <= 1'b0;
			if (wt) w_valid <= 1'b0;
			if (bt) b_ready <= 1'b0;
		end
	endtask
	// Read: address until taken, data captured at the falling edge before it is accepted.
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic at, rt;
		@(posedge ref_clk_i);
		ar_addr <= a;
		ar_valid <= 1'b1;
		r_ready <= 1'b1;
		rt = 1'b0;
		while (!rt) begin
			@(negedge ref_clk_i);
			at = ar_valid && ar_ready === 1'b1;
			rt = r_valid === 1'b1;
			d = r_data;
			r = r_resp;
			@(posedge ref_clk_i);
			if (at) ar_valid <= 1'b0;
			if (rt) r_ready <= 1'b0;
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task print_verdict;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Cuts a hang short.
	initial begin
		#300000;
		num_errors++;
		print_verdict();
	end
	// Main test sequence.
	initial begin
		repeat (2) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		rd(8'h04, dv, rv);
		check("ctrl1 reset", dv[7:0], 32'h00);
		rd(8'h14, dv, rv);
		check("ctrl5 reset", dv[7:0], 32'h4e);
		rd(8'h18, dv, rv);
		check("ctrl6 reset", dv[7:0], 32'h18);
		rd(8'h20, dv, rv);
		check("state off", dv[7:5], 32'h0);
		rd(8'h28, dv, rv);
		check("unmapped read", rv, 32'h2);
		wr(8'h28, 32'h01, rv);
		check("unmapped write", rv, 32'h2);
		wr(8'h1c, 32'h5a, rv);
		check("ctrl7 write resp", rv, 32'h0);
		rd(8'h1c, dv, rv);
		check("ctrl7", dv[7:0], 32'h5a);
		$display("test registers done");
		wr(8'h04, 32'h02, rv);
		rd(8'h20, dv, rv);
		check("poll sleeps", dv[7:5], 32'h1);
		@(posedge ref_clk_i);
		wake <= 1'b1;
		@(posedge ref_clk_i);
		wake <= 1'b0;
		repeat (3) @(negedge ref_clk_i);
		check("pll after wake", pll_en, 32'h1);
		check("sigproc waits", sigproc_en, 32'h0);
		wr(8'h04, 32'h00, rv);
		$display("test polling done");
		for (int i = 0; i < 2; i++) begin
			wr(8'h04, 32'h03, rv);
			i_rbr_radio_model.run(hs[i]);
			rd(8'h20, dv, rv);
			check("out of window", dv[7:5] == 3'h5, 32'h0);
			wr(8'h04, 32'h00, rv);
		end
		$display("test bit-check fail done");
		wr(8'h04, 32'h0b, rv);
		fork
			i_rbr_radio_model.run(19);
			begin
				@(posedge irq);
				rd(8'h0c, dv, rv);
				check("clock on", dv[0], 32'h1);
				rd(8'h20, dv, rv);
				check("receiving", dv[7:5], 32'h5);
				wr(8'h24, 32'h01, rv);
			end
		join
		wait (sigproc_en === 1'b0);
		@(negedge ref_clk_i);
		check("irq after bytes", irq, 32'h1);
		check("pll restart", pll_en, 32'h1);
		rd(8'h20, dv, rv);
		check("byte count", dv[4:0], 32'h2);
		check("start-up state", dv[7:5], 32'h2);
		rd(8'h00, dv, rv);
		check("byte one", dv[7:0], 32'ha5);
		rd(8'h00, dv, rv);
		check("byte two", dv[7:0], 32'h3c);
		rd(8'h20, dv, rv);
		check("count drained", dv[4:0], 32'h0);
		$display("test buffered done");
		wr(8'h24, 32'h01, rv);
		wr(8'h04, 32'h00, rv);
		wr(8'h14, 32'h0e, rv);
		wr(8'h04, 32'h23, rv);
		fork
			i_rbr_radio_model.run(19);
			begin
				@(posedge sout_oe);
				@(negedge ref_clk_i);
				check("no irq transparent", irq, 32'h0);
				@(posedge ref_clk_i);
				cs_active <= 1'b1;
				repeat (2) @(negedge ref_clk_i);
				check("oe while selected", sout_oe, 32'h0);
				@(posedge ref_clk_i);
				cs_active <= 1'b0;
				repeat (2) @(negedge ref_clk_i);
				check("oe released", sout_oe, 32'h1);
				check("rx active", rx_active, 32'h1);
				wr(8'h18, 32'h18, rv);
				rd(8'h20, dv, rv);
				check("restart sigproc", dv[7:5], 32'h3);
				check("count cleared", dv[4:0], 32'h0);
			end
		join
		wr(8'h04, 32'h00, rv);
		@(negedge ref_clk_i);
		check("off again", pll_en, 32'h0);
		$display("test transparent done");
		print_verdict();
	end
endmodule
`default_nettype wire
